// File: rtl/rscd_pkg.sv
// package of strap positions, defaults and decoded carrier types for the strap loader
//------------------------------------------------------------
// Operation
// - sample address straps on the first clock after reset release
// - undriven strap reads one via pull-up
// - A19 low caps mode one at 100MHz
// - A16 A15 A13 set SMBus address bits
// - A17 low enables upper bus pull-ups
// - A18 low selects 32-bit bus width
// - narrow bus keeps upper lines pulled up
// - A21 low enables hot swap startup
// - A22 low disables firmware timer
// - write strobe low selects reference clock pair
// - A24 low skips link-down full reset
// - A10 picks which interface is function 0
//------------------------------------------------------------
package rscd_pkg;
    localparam int ADDR_W          = 25;
    localparam int POS_FUNC0_SEL   = 10;
    localparam int POS_PCIX_ENDPOINT_STRAP_N     = 11;
    localparam int POS_ROOT_CPLX   = 12;
    localparam int POS_SMB_BIT2    = 13;
    localparam int POS_SMB_BIT3    = 15;
    localparam int POS_SMB_BIT5    = 16;
    localparam int POS_PULLUP_EN   = 17;
    localparam int POS_NARROW_BUS  = 18;
    localparam int POS_SPEED_LIM   = 19;
    localparam int POS_HOT_SWAP    = 21;
    localparam int POS_FW_TIMER    = 22;
    localparam int POS_CTRL_ONLY   = 23;
    localparam int POS_LINK_DOWN   = 24;
    localparam logic [6:0] SMB_ADDR_BASE = 7'h00; // bits not set by straps
    localparam int SYNC_STAGES     = 2;

    typedef struct packed {
        logic       speed_133_en;    // 1: mode one may run at 133MHz
        logic [6:0] smbus_addr;
        logic       upper_pullup_en;
        logic       bus_64bit;
        logic       upper_hold_pullup;
        logic       hot_swap_en;
        logic       fw_timer_en;
        logic       refclk_pair_sel;
        logic       link_down_reset_en;
        logic       function0_is_pcie;
        logic       pcie_endpoint_ok;
        logic       pcix_endpoint_ok;
    } rscd_cfg_t;
endpackage : rscd_pkg

// File: rtl/rscd_strap_loader.sv
// strap capture at reset release and decode into chip configuration
`timescale 1ns/1ps
module rscd_strap_loader (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic [rscd_pkg::ADDR_W-1:0] periph_addr,
    input  wire logic                       peripheral_write_strobe_n,
    input  wire logic                       smbus_addr_bit1_strap,
    output logic                            cfg_valid,
    output rscd_pkg::rscd_cfg_t             cfg
);
    import rscd_pkg::*;

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic [ADDR_W+1:0] sync1_r, sync2_r;
    logic              cap_done_r, cap_done_nxt;
    logic [ADDR_W+1:0] strap_r, strap_nxt;
    rscd_cfg_t         cfg_r, cfg_nxt;

    // two-stage capture of every strap pin; runs through reset on purpose,
    // so stage two already holds the settled strap levels when reset ends
    always_ff @(posedge clk) begin
        sync1_r <= {smbus_addr_bit1_strap, peripheral_write_strobe_n, periph_addr};
        sync2_r <= sync1_r; // only stage two is read downstream
    end

    //------------------------------------------------------------
    // capture once after release, then freeze
    //------------------------------------------------------------
    function automatic rscd_cfg_t decode(input logic [ADDR_W+1:0] s);
        rscd_cfg_t c;
        c = '0;
        c.speed_133_en       = s[POS_SPEED_LIM];
        c.smbus_addr         = SMB_ADDR_BASE;
        c.smbus_addr[5]      = s[POS_SMB_BIT5];
        c.smbus_addr[3]      = s[POS_SMB_BIT3];
        c.smbus_addr[2]      = s[POS_SMB_BIT2];
        c.smbus_addr[1]      = s[ADDR_W+1];
        c.upper_pullup_en    = ~s[POS_PULLUP_EN];
        c.bus_64bit          = s[POS_NARROW_BUS];
        c.upper_hold_pullup  = ~s[POS_NARROW_BUS] | ~s[POS_PULLUP_EN];
        c.hot_swap_en        = ~s[POS_HOT_SWAP];
        c.fw_timer_en        = s[POS_FW_TIMER];
        c.refclk_pair_sel    = ~s[ADDR_W];
        c.link_down_reset_en = s[POS_LINK_DOWN];
        c.function0_is_pcie  = s[POS_FUNC0_SEL];
        c.pcie_endpoint_ok   = ~s[POS_CTRL_ONLY] & s[POS_FUNC0_SEL]
                               & s[POS_ROOT_CPLX];
        c.pcix_endpoint_ok   = ~s[POS_CTRL_ONLY] & ~s[POS_FUNC0_SEL]
                               & ~s[POS_PCIX_ENDPOINT_STRAP_N];
        return c;
    endfunction : decode

    // first clock after release takes the synchronised pin levels
    always_comb begin
        cap_done_nxt = 1'b1;
        strap_nxt    = strap_r;
        if (!cap_done_r) begin
            strap_nxt = sync2_r;
        end
        cfg_nxt = decode(strap_nxt);
    end

    // registers; strap default equals all straps left open, config resets to zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_done_r <= 1'b0;
            strap_r    <= '1;
            cfg_r      <= '0;
        end else begin
            cap_done_r <= cap_done_nxt;
            strap_r    <= strap_nxt;
            cfg_r      <= cfg_nxt;
        end
    end

    assign cfg_valid = cap_done_r;
    assign cfg       = cfg_r;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // outputs sit at zero while reset is held
    cfg_reset_a: assert property (
        @(posedge clk) disable iff (1'b0)
        !reset_n |-> !cfg_valid && cfg_r == '0)
        else $error("config not cleared in reset");

    // valid never drops once set, until reset
    valid_hold_a: assert property (
        cap_done_r |=> cap_done_r)
        else $error("valid dropped after capture");

    // captured straps frozen after the first cycle
    hold_after_cap_a: assert property (
        cap_done_r && $past(cap_done_r) |-> $stable(strap_r))
        else $error("strap value changed after capture");

    // decoded config frozen as well
    cfg_hold_a: assert property (
        cap_done_r && $past(cap_done_r) |-> $stable(cfg_r))
        else $error("config changed after capture");

    // capture takes the synchronised pin levels
    capture_once_a: assert property (
        $rose(cap_done_r) |-> strap_r == $past(sync2_r))
        else $error("capture did not take pin levels");

    // speed limit follows its strap
    speed_map_a: assert property (
        cap_done_r |-> cfg_r.speed_133_en == strap_r[POS_SPEED_LIM])
        else $error("speed limit decode wrong");

    // strapped address bits follow their pins
    smb_map_a: assert property (
        cap_done_r |-> cfg_r.smbus_addr[5] == strap_r[POS_SMB_BIT5]
        && cfg_r.smbus_addr[3] == strap_r[POS_SMB_BIT3]
        && cfg_r.smbus_addr[2] == strap_r[POS_SMB_BIT2]
        && cfg_r.smbus_addr[1] == strap_r[ADDR_W+1])
        else $error("smbus address decode wrong");

    // address bits without a strap keep the base value
    smb_fixed_a: assert property (
        cap_done_r |-> cfg_r.smbus_addr[6] == SMB_ADDR_BASE[6]
        && cfg_r.smbus_addr[4] == SMB_ADDR_BASE[4]
        && cfg_r.smbus_addr[0] == SMB_ADDR_BASE[0])
        else $error("smbus fixed bits wrong");

    // pull-up enable is the inverse of its strap
    pullup_map_a: assert property (
        cap_done_r |-> cfg_r.upper_pullup_en != strap_r[POS_PULLUP_EN])
        else $error("pull-up decode wrong");

    // bus width follows its strap
    width_map_a: assert property (
        cap_done_r |-> cfg_r.bus_64bit == strap_r[POS_NARROW_BUS])
        else $error("bus width decode wrong");

    // narrow bus keeps upper lines pulled up
    narrow_pull_a: assert property (
        cap_done_r && !strap_r[POS_NARROW_BUS] |-> cfg_r.upper_hold_pullup)
        else $error("narrow bus lacks pull-ups");

    // wide bus with pull-ups off leaves upper lines free
    wide_free_a: assert property (
        cap_done_r && strap_r[POS_NARROW_BUS] && strap_r[POS_PULLUP_EN]
        |-> !cfg_r.upper_hold_pullup)
        else $error("wide bus holds pull-ups");

    // hot swap startup is active low
    hot_swap_a: assert property (
        cap_done_r |-> cfg_r.hot_swap_en != strap_r[POS_HOT_SWAP])
        else $error("hot swap decode wrong");

    // firmware timer follows its strap
    fw_timer_a: assert property (
        cap_done_r |-> cfg_r.fw_timer_en == strap_r[POS_FW_TIMER])
        else $error("firmware timer decode wrong");

    // reference clock pair picked by a low strobe strap
    refclk_sel_a: assert property (
        cap_done_r |-> cfg_r.refclk_pair_sel != strap_r[ADDR_W])
        else $error("clock source decode wrong");

    // link-down reset follows its strap
    link_down_a: assert property (
        cap_done_r |-> cfg_r.link_down_reset_en == strap_r[POS_LINK_DOWN])
        else $error("link down decode wrong");

    // function zero choice follows its strap
    func0_sel_a: assert property (
        cap_done_r |-> cfg_r.function0_is_pcie == strap_r[POS_FUNC0_SEL])
        else $error("function select decode wrong");

    // express endpoint flag matches the legal combination
    pcie_ep_map_a: assert property (
        cap_done_r |-> cfg_r.pcie_endpoint_ok == (!strap_r[POS_CTRL_ONLY]
        && strap_r[POS_FUNC0_SEL] && strap_r[POS_ROOT_CPLX]))
        else $error("express endpoint flag wrong");

    // bus endpoint flag matches the legal combination
    pcix_endpoint_strap_n_map_a: assert property (
        cap_done_r |-> cfg_r.pcix_endpoint_ok == (!strap_r[POS_CTRL_ONLY]
        && !strap_r[POS_FUNC0_SEL] && !strap_r[POS_PCIX_ENDPOINT_STRAP_N]))
        else $error("bus endpoint flag wrong");

    // the two endpoint modes never both claimed
    endpoint_excl_a: assert property (
        !(cfg_r.pcie_endpoint_ok && cfg_r.pcix_endpoint_ok))
        else $error("both endpoint modes flagged");

    // main scenarios
    cap_seen_c: cover property ($rose(cap_done_r));
    pcie_ep_c:  cover property (cap_done_r && cfg_r.pcie_endpoint_ok);
    pcix_endpoint_strap_n_c:  cover property (cap_done_r && cfg_r.pcix_endpoint_ok);
    narrow_c:   cover property (cap_done_r && !cfg_r.bus_64bit);
    refclk_c:   cover property (cap_done_r && cfg_r.refclk_pair_sel);
endmodule : rscd_strap_loader

// File: test/rscd_strap_board.sv
// board strap model: pull-down resistors over internal pull-ups, then bus traffic
`timescale 1ns/1ps
module rscd_strap_board (
    input  wire logic [26:0] pull_low,
    input  wire logic        bus_busy,
    input  wire logic [24:0] bus_addr,
    output logic [24:0]      periph_addr,
    output logic             strobe_n,
    output logic             bit1_strap
);
    // a fitted resistor pulls low, an open pin floats high; traffic takes over after capture
    assign periph_addr = bus_busy ? bus_addr : ~pull_low[24:0];
    assign strobe_n    = bus_busy ? ~bus_addr[0] : ~pull_low[25];
    assign bit1_strap  = ~pull_low[26];
endmodule : rscd_strap_board

// File: test/tb_top.sv
// self-checking bench for the strap loader
`timescale 1ns/1ps
module tb_top;
    import rscd_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [26:0] pull_low = 27'h0;
    logic        bus_busy = 1'b0;
    logic [24:0] bus_addr = 25'h0;
    logic [24:0] pins;
    logic        strobe_n, bit1, cfg_valid;
    rscd_cfg_t   cfg;
    int          error_cnt = 0, comparisons = 0, cycles = 0;
    logic [26:0] table_pl [6] = '{27'h0, 27'h7ffffff, 27'h0800000, 27'h0800c00,
                                  27'h5555555, 27'h2aaaaaa};
    always #20 clk = ~clk;
    rscd_strap_board rscd_strap_board_inst (.pull_low(pull_low), .bus_busy(bus_busy),
        .bus_addr(bus_addr), .periph_addr(pins), .strobe_n(strobe_n), .bit1_strap(bit1));
    rscd_strap_loader rscd_strap_loader_inst (.clk(clk), .reset_n(reset_n), .periph_addr(pins),
        .peripheral_write_strobe_n(strobe_n), .smbus_addr_bit1_strap(bit1),
        .cfg_valid(cfg_valid), .cfg(cfg));
    //--------------------------------
    // expected decode and checking
    //--------------------------------
    function automatic rscd_cfg_t expect_cfg(input logic [26:0] pl);
        logic [26:0] v;
        rscd_cfg_t   c;
        v = ~pl;
        c.speed_133_en = v[19];
        c.smbus_addr = {1'b0, v[16], 1'b0, v[15], v[13], v[26], 1'b0};
        c.upper_pullup_en = ~v[17];
        c.bus_64bit = v[18];
        c.upper_hold_pullup = ~v[18] | ~v[17];
        c.hot_swap_en = ~v[21];
        c.fw_timer_en = v[22];
        c.refclk_pair_sel = ~v[25];
        c.link_down_reset_en = v[24];
        c.function0_is_pcie = v[10];
        c.pcie_endpoint_ok = ~v[23] & v[10] & v[12];
        c.pcix_endpoint_ok = ~v[23] & ~v[10] & ~v[11];
        return c;
    endfunction : expect_cfg
    task check(input string what, input logic [18:0] exp, input logic [18:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task close_out;
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // one reset with given straps, then bus traffic that must be ignored
    task capture(input logic [26:0] pl);
        @(posedge clk);
        reset_n  <= 1'b0;
        bus_busy <= 1'b0;
        pull_low <= pl;
        repeat (4) @(posedge clk);
        check("cfg in reset", 19'h0, {cfg_valid, cfg});
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check("cfg captured", {1'b1, expect_cfg(pl)}, {cfg_valid, cfg});
        @(posedge clk);
        bus_busy <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            bus_addr <= {pl[24:0]} ^ (25'h1 << (i * 4));
        end
        #1 check("cfg held", {1'b1, expect_cfg(pl)}, {cfg_valid, cfg});
    endtask : capture
    // timeout ceiling well above six captures
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    //--------------------------------
    // main sequence: defaults, all low, both endpoint combos, patterns
    //--------------------------------
    initial begin
        repeat (3) @(posedge clk);
        foreach (table_pl[k]) capture(table_pl[k]);
        close_out();
    end
endmodule : tb_top
